// ---- common/wdt_pkg.sv ----
// Purpose: Shared constants and types of the watchdog timeout and lock block.
// Assumes: APB register slave with 32-bit data, one aligned word per register.
// Notes: Registers are eight bits wide and sit in the low byte of the word.
package wdt_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;

    // Byte addresses of the registers.
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] LOCK_OFFSET = 8'h04;
    localparam logic [7:0] RESTART_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] MASK_OFFSET = 8'h10;

    // Field positions of watchdog_control.
    localparam int unsigned FLAG_BIT = 7;
    localparam int unsigned IRQ_EN_BIT = 6;
    localparam int unsigned SEL3_BIT = 5;
    localparam int unsigned UNLOCK_BIT = 4;
    localparam int unsigned SRE_BIT = 3;
    localparam int unsigned SEL2_BIT = 2;

    // Field positions and patterns of watchdog_lock_control.
    localparam int unsigned ARM_BIT = 0;
    localparam int unsigned LEVEL_LO_BIT = 1;
    localparam int unsigned LEVEL_HI_BIT = 2;
    localparam logic [2:0] LOCK_ARM_PATTERN = 3'h7;
    localparam logic [2:0] LOCK_FULL_PATTERN = 3'h4;
    localparam logic [2:0] LOCK_SIX_PATTERN = 3'h2;
    localparam logic [6:0] FULL_LOCK_MASK = 7'h7F;
    localparam logic [6:0] SIX_LOCK_MASK = 7'h3F;
    localparam logic [6:0] NO_LOCK_MASK = 7'h00;

    // Reset values.
    localparam logic SRE_RESET = 1'h0;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [2:0] EVENT_RESET = 3'h0;

    // Timed sequences stay open for four clock cycles.
    localparam int unsigned WINDOW_W = 3;
    localparam logic [2:0] TIMED_WINDOW_CYCLES = 3'h4;

    // Timeout selection: 2K oscillator cycles doubled per code up to 1024K.
    localparam int unsigned COUNT_W = 20;
    localparam logic [20:0] BASE_TICKS = 21'h000800;
    localparam logic [3:0] SEL_MAX = 4'h9;

    // Interrupt status events.
    localparam int unsigned EVENT_W = 3;
    localparam int unsigned EV_TIMEOUT = 0;
    localparam int unsigned EV_LOCKED = 1;
    localparam int unsigned EV_ABORT = 2;

    typedef enum logic [1:0] {
        LOCK_OPEN,
        LOCK_ARMED,
        LOCK_SIX,
        LOCK_FULL
    } lock_state_type;

endpackage

// ---- rtl/timeout_counter.sv ----
// Purpose: Counts oscillator ticks and pulses once per selected timeout.
// Assumes: tick_in is a one-cycle pulse per slow oscillator period.
// Notes: Reserved select codes behave as the longest timeout.
`timescale 1ns/10ps
`default_nettype none
module timeout_counter (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic enable_in,
    input wire logic restart_in,
    input wire logic tick_in,
    input wire logic [3:0] select_in,
    output logic timeout_out
);
    logic [wdt_pkg::COUNT_W-1:0] count;
    logic [wdt_pkg::COUNT_W-1:0] next_count;
    logic next_timeout;
    logic [3:0] sel_eff;
    logic [20:0] span;
    logic [wdt_pkg::COUNT_W-1:0] terminal;

    // Counting slow ticks, not clock cycles, makes the real timeout follow
    // the oscillator's actual period. [RULE2]
    always_comb begin
        sel_eff = (select_in > wdt_pkg::SEL_MAX) ? wdt_pkg::SEL_MAX
                                                 : select_in;
        span = wdt_pkg::BASE_TICKS << sel_eff; // [RULE1]
        terminal = wdt_pkg::COUNT_W'(span - 21'h000001);
        next_count = count;
        next_timeout = 1'b0;
        if (!enable_in || restart_in) begin
            next_count = '0;
        end else if (tick_in) begin
            if (count >= terminal) begin
                next_count = '0;
                next_timeout = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count <= '0;
            timeout_out <= 1'b0;
        end else begin
            count <= next_count;
            timeout_out <= next_timeout;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/watchdog_lock.sv ----
// Purpose: Watchdog control with timeout selection and a configuration lock.
// Assumes: APB master in the same clock domain; oscillator ticks arrive as
// one-cycle pulses synchronous to clk_in.
// Notes: Each access takes one wait state; outputs are all registered.
// Contract
// [RULE1] Select codes 0 to 9 give 2K to 1024K oscillator cycles, 10 to 15 are reserved.
// [RULE2] The timeout is counted in slow oscillator cycles, not clock cycles.
// [RULE3] The upper five bits of the lock register read zero and ignore writes.
// [RULE4] Locked control bits reject every software write until hardware reset.
// [RULE5] Arming write 111 then within four cycles write 100 locks bits six to zero.
// [RULE6] Arming write 111 then within four cycles write 010 locks bits five to zero.
// [RULE7] Software should configure then lock early, six-bit lock for interrupt use.
// [RULE8] A missing second write within four cycles drops the armed state, no lock.
// [RULE9] Clearing reset enable or changing select needs change-unlock set first.
// [RULE10] Change-unlock clears by itself four clock cycles after it is written.
// [RULE11] With both enables set, the first timeout interrupts then falls to reset mode.
// [RULE12] Software should restart the count before changing the select bits.
`timescale 1ns/10ps
`default_nettype none
module watchdog_lock (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic osc_tick_in,
    output logic irq_out,
    output logic system_reset_out
);
    // Bus state.
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // Watchdog control state.
    logic irq_flag;
    logic irq_en;
    logic sre;
    logic [3:0] sel;
    logic [2:0] unlock_cnt;
    logic next_irq_flag;
    logic next_irq_en;
    logic next_sre;
    logic [3:0] next_sel;
    logic [2:0] next_unlock_cnt;
    logic next_system_reset;

    // Lock state.
    wdt_pkg::lock_state_type lock_state;
    wdt_pkg::lock_state_type next_lock_state;
    logic [2:0] arm_cnt;
    logic [2:0] next_arm_cnt;

    // Interrupt state.
    logic [2:0] events;
    logic [2:0] mask;
    logic [2:0] next_events;
    logic [2:0] next_mask;
    logic next_irq;

    // Decode and helpers.
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] control_view;
    logic [7:0] lock_view;
    logic [6:0] lock_mask;
    logic [3:0] sel_lock;
    logic unlock_open;
    logic timeout;
    logic restart;
    logic wd_enable;
    logic [2:0] ev_set;

    timeout_counter counter_inst (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .enable_in(wd_enable),
        .restart_in(restart),
        .tick_in(osc_tick_in),
        .select_in(sel),
        .timeout_out(timeout)
    );

    always_comb begin
        access = psel_in && penable_in && pready_out;
        wr = access && pwrite_in;
        rd = access && !pwrite_in;
        wbyte = pwdata_in[7:0];
        mapped = (paddr_in == wdt_pkg::CONTROL_OFFSET) ||
                 (paddr_in == wdt_pkg::LOCK_OFFSET) ||
                 (paddr_in == wdt_pkg::RESTART_OFFSET) ||
                 (paddr_in == wdt_pkg::STATUS_OFFSET) ||
                 (paddr_in == wdt_pkg::MASK_OFFSET);
        unlock_open = (unlock_cnt != '0);
        wd_enable = sre || irq_en;
        restart = wr && (paddr_in == wdt_pkg::RESTART_OFFSET);
        case (lock_state)
            wdt_pkg::LOCK_FULL: lock_mask = wdt_pkg::FULL_LOCK_MASK;
            wdt_pkg::LOCK_SIX: lock_mask = wdt_pkg::SIX_LOCK_MASK;
            default: lock_mask = wdt_pkg::NO_LOCK_MASK;
        endcase
        sel_lock = {lock_mask[wdt_pkg::SEL3_BIT],
                    lock_mask[wdt_pkg::SEL2_BIT:0]};
        control_view = '0;
        control_view[wdt_pkg::FLAG_BIT] = irq_flag;
        control_view[wdt_pkg::IRQ_EN_BIT] = irq_en;
        control_view[wdt_pkg::SEL3_BIT] = sel[3];
        control_view[wdt_pkg::UNLOCK_BIT] = unlock_open;
        control_view[wdt_pkg::SRE_BIT] = sre;
        control_view[wdt_pkg::SEL2_BIT:0] = sel[2:0];
        // Upper five bits are never stored and read as zero. [RULE3]
        lock_view = '0;
        lock_view[wdt_pkg::ARM_BIT] = (lock_state == wdt_pkg::LOCK_ARMED);
        lock_view[wdt_pkg::LEVEL_LO_BIT] = (lock_state == wdt_pkg::LOCK_SIX);
        lock_view[wdt_pkg::LEVEL_HI_BIT] = (lock_state == wdt_pkg::LOCK_FULL);
    end

    // APB answer: one wait state, data and error registered with pready.
    always_comb begin
        next_pready = psel_in && penable_in && !pready_out;
        next_pslverr = 1'b0;
        next_prdata = '0;
        if (next_pready) begin
            next_pslverr = !mapped;
            if (!pwrite_in) begin
                case (paddr_in)
                    wdt_pkg::CONTROL_OFFSET: next_prdata[7:0] = control_view;
                    wdt_pkg::LOCK_OFFSET: next_prdata[7:0] = lock_view;
                    wdt_pkg::STATUS_OFFSET: next_prdata[2:0] = events;
                    wdt_pkg::MASK_OFFSET: next_prdata[2:0] = mask;
                    default: next_prdata = '0;
                endcase
            end
        end
    end

    // Watchdog control register and timeout actions.
    always_comb begin
        next_irq_flag = irq_flag;
        next_irq_en = irq_en;
        next_sre = sre;
        next_sel = sel;
        next_system_reset = 1'b0;
        next_unlock_cnt = unlock_cnt;
        if (unlock_open) begin
            next_unlock_cnt = unlock_cnt - 3'h1; // [RULE10]
        end
        if (wr && paddr_in == wdt_pkg::CONTROL_OFFSET) begin
            // The flag is outside every lock level and is cleared by a one.
            if (wbyte[wdt_pkg::FLAG_BIT]) begin
                next_irq_flag = 1'b0;
            end
            if (!lock_mask[wdt_pkg::IRQ_EN_BIT]) begin // [RULE4]
                next_irq_en = wbyte[wdt_pkg::IRQ_EN_BIT];
            end
            if (!lock_mask[wdt_pkg::UNLOCK_BIT] &&
                wbyte[wdt_pkg::UNLOCK_BIT]) begin
                next_unlock_cnt = wdt_pkg::TIMED_WINDOW_CYCLES; // [RULE10]
            end
            if (!lock_mask[wdt_pkg::SRE_BIT]) begin // [RULE4]
                // Setting is always allowed; clearing needs the open window.
                if (wbyte[wdt_pkg::SRE_BIT]) begin
                    next_sre = 1'b1;
                end else if (unlock_open) begin // [RULE9]
                    next_sre = 1'b0;
                end
            end
            if (unlock_open) begin // [RULE9]
                for (int i = 0; i < 4; i++) begin
                    if (!sel_lock[i]) begin // [RULE4]
                        next_sel[i] = (i == 3) ? wbyte[wdt_pkg::SEL3_BIT]
                                               : wbyte[i];
                    end
                end
            end
        end
        // Hardware actions come last so a timeout beats a same-cycle clear.
        if (timeout) begin
            if (irq_en) begin
                next_irq_flag = 1'b1;
                if (sre) begin
                    next_irq_en = 1'b0; // [RULE11]
                end
            end else if (sre) begin
                next_system_reset = 1'b1; // [RULE11]
            end
        end
    end

    // Lock sequence: arm, then the level write within the timed window.
    always_comb begin
        next_lock_state = lock_state;
        next_arm_cnt = arm_cnt;
        ev_set = '0;
        case (lock_state)
            wdt_pkg::LOCK_OPEN: begin
                if (wr && paddr_in == wdt_pkg::LOCK_OFFSET &&
                    wbyte[2:0] == wdt_pkg::LOCK_ARM_PATTERN) begin
                    next_lock_state = wdt_pkg::LOCK_ARMED;
                    next_arm_cnt = wdt_pkg::TIMED_WINDOW_CYCLES;
                end
            end
            wdt_pkg::LOCK_ARMED: begin
                next_arm_cnt = arm_cnt - 3'h1;
                if (wr && paddr_in == wdt_pkg::LOCK_OFFSET) begin
                    next_arm_cnt = '0;
                    if (wbyte[2:0] == wdt_pkg::LOCK_FULL_PATTERN) begin
                        next_lock_state = wdt_pkg::LOCK_FULL; // [RULE5]
                        ev_set[wdt_pkg::EV_LOCKED] = 1'b1;
                    end else if (wbyte[2:0] == wdt_pkg::LOCK_SIX_PATTERN) begin
                        next_lock_state = wdt_pkg::LOCK_SIX; // [RULE6]
                        ev_set[wdt_pkg::EV_LOCKED] = 1'b1;
                    end else begin
                        next_lock_state = wdt_pkg::LOCK_OPEN;
                        ev_set[wdt_pkg::EV_ABORT] = 1'b1;
                    end
                end else if (arm_cnt == 3'h1) begin
                    next_lock_state = wdt_pkg::LOCK_OPEN; // [RULE8]
                    ev_set[wdt_pkg::EV_ABORT] = 1'b1;
                end
            end
            // Once applied, a lock level holds until reset. [RULE4]
            wdt_pkg::LOCK_SIX: next_lock_state = wdt_pkg::LOCK_SIX;
            wdt_pkg::LOCK_FULL: next_lock_state = wdt_pkg::LOCK_FULL;
            default: next_lock_state = wdt_pkg::LOCK_OPEN;
        endcase
        ev_set[wdt_pkg::EV_TIMEOUT] = timeout && irq_en;
    end

    // Sticky events: a status read clears them, a new event wins over it.
    always_comb begin
        next_events = events;
        next_mask = mask;
        // Only the bits that the read returned are cleared, so an event that
        // lands between data capture and the access edge is not lost.
        if (rd && paddr_in == wdt_pkg::STATUS_OFFSET) begin
            next_events = events & ~prdata_out[wdt_pkg::EVENT_W-1:0];
        end
        next_events = next_events | ev_set;
        if (wr && paddr_in == wdt_pkg::MASK_OFFSET) begin
            next_mask = wbyte[wdt_pkg::EVENT_W-1:0];
        end
        next_irq = |(next_events & next_mask);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_out <= '0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            prdata_out <= next_prdata;
            pready_out <= next_pready;
            pslverr_out <= next_pslverr;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_flag <= 1'b0;
            irq_en <= 1'b0;
            sre <= wdt_pkg::SRE_RESET;
            sel <= wdt_pkg::SEL_RESET;
            unlock_cnt <= '0;
            system_reset_out <= 1'b0;
        end else begin
            irq_flag <= next_irq_flag;
            irq_en <= next_irq_en;
            sre <= next_sre;
            sel <= next_sel;
            unlock_cnt <= next_unlock_cnt;
            system_reset_out <= next_system_reset;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lock_state <= wdt_pkg::LOCK_OPEN;
            arm_cnt <= '0;
        end else begin
            lock_state <= next_lock_state;
            arm_cnt <= next_arm_cnt;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            events <= wdt_pkg::EVENT_RESET;
            mask <= wdt_pkg::EVENT_RESET;
            irq_out <= 1'b0;
        end else begin
            events <= next_events;
            mask <= next_mask;
            irq_out <= next_irq;
        end
    end
endmodule
`default_nettype wire

// ---- tb/watchdog_lock_sva.sv ----
// Purpose: Port level checks of the watchdog timeout and lock block.
// Assumes: One clock domain; the master keeps APB setup and access order.
// Notes: Tick to reset latency is allowed a window of a few edges.
`timescale 1ns/10ps
`default_nettype none
module watchdog_lock_sva (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic osc_tick_in,
    input wire logic irq_out,
    input wire logic system_reset_out
);
    logic mapped;
    logic lock_read;
    always_comb mapped = paddr_in inside {wdt_pkg::CONTROL_OFFSET,
        wdt_pkg::LOCK_OFFSET, wdt_pkg::RESTART_OFFSET,
        wdt_pkg::STATUS_OFFSET, wdt_pkg::MASK_OFFSET};
    always_comb lock_read = paddr_in == wdt_pkg::LOCK_OFFSET && !pwrite_in;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    sequence s_waiting;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_answer;
        pready_out ##1 !pready_out;
    endsequence
    a_ready_one_wait: assert property (s_waiting |=> s_answer)
        else $error("pready did not follow one wait state");
    a_ready_in_access: assert property (pready_out |->
        $past(psel_in && penable_in)) else $error("pready outside access");
    a_error_unmapped: assert property (pslverr_out |-> pready_out &&
        !$past(mapped) && prdata_out == 32'h0)
        else $error("pslverr on a mapped address");
    a_okay_mapped: assert property (pready_out && !pslverr_out |->
        $past(mapped)) else $error("unmapped address not refused");
    a_upper_bytes_zero: assert property (pready_out |->
        prdata_out[31:8] == 24'h0) else $error("read upper bits not zero");
    a_lock_high_zero: assert property (
        pready_out && $past(lock_read) |-> prdata_out[7:3] == 5'h00)
        else $error("lock register reserved bits not zero");
    a_reset_from_tick: assert property (system_reset_out |->
        $past(osc_tick_in) || $past(osc_tick_in, 2) ||
        $past(osc_tick_in, 3) || $past(osc_tick_in, 4))
        else $error("system reset without an oscillator tick");
    a_reset_one_cycle: assert property (
        system_reset_out |=> !system_reset_out)
        else $error("system reset pulse longer than one cycle");
endmodule
bind watchdog_lock watchdog_lock_sva u_sva (.clk_in, .arst_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .osc_tick_in, .irq_out, .system_reset_out);
`default_nettype wire

// ---- tb/watchdog_lock_bench.sv ----
// Purpose: Self-checking bench for the watchdog timeout and lock block.
// Assumes: APB driven by the bench right after rising edges.
// Notes: Only select codes 0 to 2 run to timeout, to keep the run short.
`timescale 1ns/10ps
`default_nettype none
module watchdog_lock_bench;
    localparam logic [7:0] CTL = wdt_pkg::CONTROL_OFFSET;
    localparam logic [7:0] LCK = wdt_pkg::LOCK_OFFSET;
    localparam logic [7:0] RST = wdt_pkg::RESTART_OFFSET;
    localparam logic [7:0] STA = wdt_pkg::STATUS_OFFSET;
    localparam logic [7:0] MSK = wdt_pkg::MASK_OFFSET;
    logic clk_in = 1'h0;
    logic arst_n_in = 1'h0;
    logic psel_in = 1'h0;
    logic penable_in = 1'h0;
    logic pwrite_in = 1'h0;
    logic osc_tick_in = 1'h0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out, rdata;
    logic pready_out, pslverr_out, irq_out, system_reset_out, rerr;
    logic [7:0] mctl;
    logic [6:0] lk;
    int n_errors = 0;
    int compares = 0;
    int i;
    watchdog_lock u_watchdog_lock (.clk_in, .arst_n_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
        .pready_out, .pslverr_out, .osc_tick_in, .irq_out, .system_reset_out);
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    task automatic complete_run();
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_range(input string what, input int lo, hi, got);
        compares++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // Locked bits keep their value; select and clearing of the reset
    // enable need the change window, and the unlock bit reads 0 after it.
    function automatic logic [7:0] next_ctrl(logic [7:0] o, d, bit win);
        logic [7:0] n;
        n = {o[7] & ~d[7], d[6:5], 1'h0, d[3:0]};
        if (!win) begin
            n[5] = o[5];
            n[2:0] = o[2:0];
            n[3] = o[3] | d[3];
        end
        for (int k = 0; k < 7; k++) begin
            if (lk[k]) n[k] = o[k];
        end
        return n;
    endfunction
    task automatic idle(input int n);
        psel_in <= 1'h0;
        penable_in <= 1'h0;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, d);
        psel_in <= 1'h1;
        penable_in <= 1'h0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= {24'h0, d};
        @(posedge clk_in);
        penable_in <= 1'h1;
        // Only the bench watchdog ends a wait for an answer that never comes.
        do begin
            @(posedge clk_in);
        end while (pready_out !== 1'h1);
        rdata = prdata_out;
        rerr = pslverr_out;
    endtask
    // With hold set the next access follows at once, three edges later.
    task automatic wr(input logic [7:0] a, d, input bit win, hold);
        apb(1'h1, a, d);
        if (a == CTL) mctl = next_ctrl(mctl, d, win);
        if (!hold) idle(1);
    endtask
    task automatic rd(input logic [7:0] a, e, input bit err);
        apb(1'h0, a, 8'h00);
        check("prdata", {24'h0, e}, rdata);
        check("pslverr", {31'h0, err}, {31'h0, rerr});
        idle(1);
    endtask
    task automatic chk_irq(input logic e);
        @(posedge clk_in);
        check("irq_out", {31'h0, e}, {31'h0, irq_out});
    endtask
    task automatic rst();
        arst_n_in <= 1'h0;
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'h1;
        @(posedge clk_in);
        mctl = 8'h00;
        lk = 7'h00;
    endtask
    task automatic run_ticks(input bit on_irq, rnd, input int exp);
        int cnt;
        bit r;
        cnt = 0;
        repeat (3 * exp + 40) begin
            @(posedge clk_in);
            if ((on_irq ? irq_out : system_reset_out) === 1'h1) break;
            r = rnd ? 1'($urandom % 2) : 1'h1;
            osc_tick_in <= r;
            cnt += r;
        end
        osc_tick_in <= 1'h0;
        check_range("timeout ticks", exp, exp + 5, cnt);
    endtask
    task automatic set_sel(input logic [3:0] s);
        wr(RST, 8'h00, 1'h0, 1'h0);
        wr(CTL, 8'h18, 1'h0, 1'h1);
        wr(CTL, {2'h0, s[3], 2'h1, s[2:0]}, 1'h1, 1'h0);
    endtask
    initial begin
        #240000;
        n_errors++;
        complete_run();
    end
    initial begin
        void'($urandom(98794));
        rst();
        rd(CTL, 8'h00, 1'h0);
        rd(LCK, 8'h00, 1'h0);
        rd(STA, 8'h00, 1'h0);
        rd(MSK, 8'h00, 1'h0);
        rd(8'h14, 8'h00, 1'h1);
        wr(LCK, 8'hF8, 1'h0, 1'h0);
        rd(LCK, 8'h00, 1'h0);
        wr(CTL, 8'h08, 1'h0, 1'h0);
        wr(CTL, 8'h05, 1'h0, 1'h0);
        rd(CTL, mctl, 1'h0);
        wr(CTL, 8'h18, 1'h0, 1'h0);
        idle(1);
        wr(CTL, 8'h01, 1'h0, 1'h0);
        rd(CTL, mctl, 1'h0);
        for (i = 0; i < 16; i++) begin
            wr(CTL, 8'h18, 1'h0, i[0]);
            wr(CTL, {2'h0, i[3], 2'h1, i[2:0]}, 1'h1, 1'h0);
            rd(CTL, mctl, 1'h0);
        end
        for (i = 0; i < 3; i++) begin
            set_sel(i[3:0]);
            run_ticks(1'h0, i == 0, 2048 << i);
        end
        set_sel(4'h0);
        wr(MSK, 8'h01, 1'h0, 1'h0);
        wr(CTL, 8'h48, 1'h0, 1'h0);
        wr(RST, 8'h00, 1'h0, 1'h0);
        run_ticks(1'h1, 1'h0, 2048);
        mctl = 8'h88;
        rd(CTL, mctl, 1'h0);
        rd(STA, 8'h01, 1'h0);
        chk_irq(1'h0);
        wr(CTL, 8'h88, 1'h0, 1'h0);
        rd(CTL, mctl, 1'h0);
        wr(RST, 8'h00, 1'h0, 1'h0);
        run_ticks(1'h0, 1'h0, 2048);
        wr(MSK, 8'h02, 1'h0, 1'h0);
        wr(LCK, 8'h07, 1'h0, 1'h0);
        wr(LCK, 8'h02, 1'h0, 1'h0);
        lk = wdt_pkg::SIX_LOCK_MASK;
        chk_irq(1'h1);
        rd(LCK, 8'h02, 1'h0);
        rd(STA, 8'h02, 1'h0);
        wr(CTL, 8'h10, 1'h0, 1'h1);
        wr(CTL, 8'h41, 1'h0, 1'h0);
        rd(CTL, mctl, 1'h0);
        wr(LCK, 8'h07, 1'h0, 1'h0);
        rd(LCK, 8'h02, 1'h0);
        rst();
        rd(LCK, 8'h00, 1'h0);
        rd(CTL, 8'h00, 1'h0);
        wr(MSK, 8'h04, 1'h0, 1'h0);
        wr(LCK, 8'h07, 1'h0, 1'h0);
        idle(1);
        wr(LCK, 8'h04, 1'h0, 1'h0);
        rd(LCK, 8'h00, 1'h0);
        chk_irq(1'h1);
        wr(LCK, 8'h07, 1'h0, 1'h1);
        wr(LCK, 8'h03, 1'h0, 1'h0);
        rd(STA, 8'h04, 1'h0);
        rd(LCK, 8'h00, 1'h0);
        set_sel(4'h1);
        wr(LCK, 8'h07, 1'h0, 1'h1);
        wr(LCK, 8'h04, 1'h0, 1'h0);
        lk = wdt_pkg::FULL_LOCK_MASK;
        rd(LCK, 8'h04, 1'h0);
        wr(CTL, 8'h10, 1'h0, 1'h1);
        wr(CTL, 8'h40, 1'h0, 1'h0);
        rd(CTL, mctl, 1'h0);
        complete_run();
    end
endmodule
`default_nettype wire
